// ### logic/rbs_params.svh
// Register map, field positions, reset values and codes for the self-test status block
`ifndef RBS_PARAMS_SVH
`define RBS_PARAMS_SVH

`define RBS_ADDR_W          8
`define RBS_OFF_CFG         8'h44
`define RBS_OFF_CTRL        8'h48
`define RBS_OFF_IRQ_STAT    8'h50
`define RBS_OFF_IRQ_CLR     8'h54
`define RBS_OFF_IRQ_EN      8'h58

`define RBS_CFG_RESET       32'h02000000
`define RBS_CTRL_RESET      32'h02000000
`define RBS_THR_RESET       2'h2
`define RBS_THR_HI          25
`define RBS_THR_LO          24
`define RBS_ERR_EXCL_BIT    20
`define RBS_CONV_EXCL_BIT   16
`define RBS_RUNNING_BIT     8
`define RBS_RESULT_HI       3
`define RBS_RESULT_LO       0
`define RBS_LAUNCH_BIT      8
`define RBS_CLEAR_BIT       16
`define RBS_SELECT_HI       3
`define RBS_SELECT_LO       0

`define RBS_SEL_NONE        4'h0
`define RBS_CODE_FAIL       4'hF
`define RBS_CODE_CLEAR      4'h0

`define RBS_EV_W            3
`define RBS_EV_PASS         0
`define RBS_EV_FAIL         1
`define RBS_EV_REFUSED      2

`define RBS_LANE_B0         0
`define RBS_LANE_B1         1
`define RBS_LANE_B2         2
`define RBS_LANE_B3         3

`endif

// ### logic/rbs_pkg.sv
// Types shared by the self-test status block and its neighbours
package rbs_pkg;

	// Run state of the self-test sequencer
	typedef enum logic [1:0] {
		RBS_IDLE = 2'b00,
		RBS_RUN  = 2'b01
	} rbs_state_e;

	// Everything the test engine needs to carry out one self-test
	typedef struct packed {
		logic [3:0] select;
		logic [1:0] adc_test_threshold;
		logic       dual_path_error_test_exclude;
		logic       dual_path_conv_test_exclude;
	} rbs_test_req_s;

	// Finished-test report from the test engine
	typedef struct packed {
		logic done;
		logic pass;
	} rbs_test_rsp_s;

endpackage

// ### logic/rbs_bist_status.sv
// Self-test configuration and status registers of the resolver converter, APB slave
`include "rbs_params.svh"

// What this block does
// - Threshold field bits 25:24 picks pass window 16, 8, 32 or 64 LSB.
// - After reset threshold is 10 and the register reads 0x02000000.
// - Bit 20 set drops the dual path error from the conversion error test.
// - Bit 16 set drops the dual path conversion from the conversion test.
// - Bit 8 reads 1 while a self-test runs, else 0.
// - No new test starts while running; software waits for the flag to drop.
// - Outcome of the latest test sits in result bits 3:0.
// - A passing test stores its own selection code as result.
// - A failing test stores 1111 as result.
// - Selection 0000 starts nothing and stores 0000 without judgement.
// - Codes 0101, 0110, 0111 run angle tests at 0, 45 and 270 degrees.
// - Other codes select amplitude, signal, disconnect, conversion and short checks.
// - Reserved bits read their reset value; software writes them back unchanged.
// - Registers accept 8, 16 and 32 bit accesses.
// - Writing launch bit starts the selected test; the bit clears itself soon.
// - Writing clear bit zeroes the result; the bit clears itself soon.
module rbs_bist_status (
	input  wire logic                  CLK_IN,
	input  wire logic                  RESET_IN,
	input  wire logic                  PSEL_IN,
	input  wire logic                  PENABLE_IN,
	input  wire logic                  PWRITE_IN,
	input  wire logic [7:0]            PADDR_IN,
	input  wire logic [31:0]           PWDATA_IN,
	input  wire logic [3:0]            PSTRB_IN,
	output logic      [31:0]           PRDATA_OUT,
	output logic                       PREADY_OUT,
	output logic                       PSLVERR_OUT,
	output logic                       IRQ_OUT,
	output rbs_pkg::rbs_test_req_s     TEST_REQ_OUT,
	output logic                       TEST_START_OUT,
	input  wire rbs_pkg::rbs_test_rsp_s TEST_RSP_IN
);

	// Register state
	logic [1:0]             adc_test_threshold;
	logic                   dual_path_error_test_exclude;
	logic                   dual_path_conv_test_exclude;
	logic [3:0]             self_test_result_code;
	logic [3:0]             self_test_select;
	logic                   self_test_launch;
	logic                   self_test_result_clear;
	logic [3:0]             captured_select;
	rbs_pkg::rbs_state_e    state;
	logic [`RBS_EV_W-1:0]   irq_status;
	logic [`RBS_EV_W-1:0]   irq_enable;

	// Bus decode
	logic                   access;
	logic                   wr_cfg;
	logic                   wr_ctrl;
	logic                   wr_clr;
	logic                   wr_en;
	logic                   mapped;
	logic [31:0]            read_word;

	// Sequencer decisions
	logic                   start_ok;
	logic                   refused;
	logic                   zero_select;
	logic                   test_done;
	logic [`RBS_EV_W-1:0]   events;
	logic [`RBS_EV_W-1:0]   next_irq_status;
	logic [`RBS_EV_W-1:0]   next_irq_enable;

	// Byte-lane write enables, one per field
	logic                   thr_we;
	logic                   opt_we;
	logic                   sel_we;
	logic                   launch_we;
	logic                   clear_we;
	logic                   irq_clr_we;
	logic                   irq_en_we;

	// Bus phase and run state helpers
	logic                   first_access;
	logic                   running;
	logic                   idle;
	logic                   zero_launch;

	// Access phase is taken at the edge where our registered ready is high
	assign access  = PSEL_IN & PENABLE_IN & PREADY_OUT;
	assign wr_cfg  = access & PWRITE_IN & (PADDR_IN == `RBS_OFF_CFG);
	assign wr_ctrl = access & PWRITE_IN & (PADDR_IN == `RBS_OFF_CTRL);
	assign wr_clr  = access & PWRITE_IN & (PADDR_IN == `RBS_OFF_IRQ_CLR);
	assign wr_en   = access & PWRITE_IN & (PADDR_IN == `RBS_OFF_IRQ_EN);

	// One enable per field, qualified by the byte lane that carries it
	assign thr_we     = wr_cfg & PSTRB_IN[`RBS_LANE_B3];
	assign opt_we     = wr_cfg & PSTRB_IN[`RBS_LANE_B2];
	assign sel_we     = wr_ctrl & PSTRB_IN[`RBS_LANE_B0];
	assign launch_we  = wr_ctrl & PSTRB_IN[`RBS_LANE_B1] & PWDATA_IN[`RBS_LAUNCH_BIT];
	assign clear_we   = wr_ctrl & PSTRB_IN[`RBS_LANE_B2] & PWDATA_IN[`RBS_CLEAR_BIT];
	assign irq_clr_we = wr_clr & PSTRB_IN[`RBS_LANE_B0];
	assign irq_en_we  = wr_en & PSTRB_IN[`RBS_LANE_B0];

	// First access cycle: the edge that raises ready and loads read data
	// Gating with ready keeps a held access from being answered twice
	assign first_access = PSEL_IN & PENABLE_IN & ~PREADY_OUT;

	// Run state as plain flags for the read mux and the launch logic
	assign running = (state == rbs_pkg::RBS_RUN);
	assign idle    = (state == rbs_pkg::RBS_IDLE);

	// Address map check, unmapped addresses answer with an error
	always_comb begin
		case (PADDR_IN)
			`RBS_OFF_CFG,
			`RBS_OFF_CTRL,
			`RBS_OFF_IRQ_STAT,
			`RBS_OFF_IRQ_CLR,
			`RBS_OFF_IRQ_EN: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// Read mux; reserved bits show their reset value
	always_comb begin
		read_word = 32'h00000000;
		case (PADDR_IN)
			`RBS_OFF_CFG: begin
				read_word = `RBS_CFG_RESET;
				read_word[`RBS_THR_HI:`RBS_THR_LO] = adc_test_threshold;
				read_word[`RBS_ERR_EXCL_BIT] = dual_path_error_test_exclude;
				read_word[`RBS_CONV_EXCL_BIT] = dual_path_conv_test_exclude;
				read_word[`RBS_RUNNING_BIT] = running;
				read_word[`RBS_RESULT_HI:`RBS_RESULT_LO] = self_test_result_code;
			end
			`RBS_OFF_CTRL: begin
				read_word = `RBS_CTRL_RESET;
				read_word[`RBS_CLEAR_BIT] = self_test_result_clear;
				read_word[`RBS_LAUNCH_BIT] = self_test_launch;
				read_word[`RBS_SELECT_HI:`RBS_SELECT_LO] = self_test_select;
			end
			`RBS_OFF_IRQ_STAT: begin
				read_word[`RBS_EV_W-1:0] = irq_status;
			end
			`RBS_OFF_IRQ_EN: begin
				read_word[`RBS_EV_W-1:0] = irq_enable;
			end
			default: begin
				read_word = 32'h00000000;
			end
		endcase
	end

	// APB ready: one wait state, then a one-cycle pulse
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			PREADY_OUT <= 1'b0;
		end else begin
			PREADY_OUT <= first_access;
		end
	end

	// Error answer for unmapped addresses, aligned with ready
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			PSLVERR_OUT <= 1'b0;
		end else begin
			PSLVERR_OUT <= first_access & ~mapped;
		end
	end

	// Read data stands only in the ready cycle
	// Zero outside it keeps stale words off the bus
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			PRDATA_OUT <= 32'h00000000;
		end else if (first_access & ~PWRITE_IN & mapped) begin
			PRDATA_OUT <= read_word;
		end else begin
			PRDATA_OUT <= 32'h00000000;
		end
	end

	// Threshold field, carried by the top byte lane
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			adc_test_threshold <= `RBS_THR_RESET;
		end else if (thr_we) begin
			adc_test_threshold <= PWDATA_IN[`RBS_THR_HI:`RBS_THR_LO];
		end
	end

	// Dual path options, both in the third byte lane
	// Writes to reserved bits are dropped, so they keep their reset value
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			dual_path_error_test_exclude <= 1'b0;
			dual_path_conv_test_exclude  <= 1'b0;
		end else if (opt_we) begin
			dual_path_error_test_exclude <= PWDATA_IN[`RBS_ERR_EXCL_BIT];
			dual_path_conv_test_exclude  <= PWDATA_IN[`RBS_CONV_EXCL_BIT];
		end
	end

	// Selection field of the control register
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			self_test_select <= `RBS_SEL_NONE;
		end else if (sel_we) begin
			self_test_select <= PWDATA_IN[`RBS_SELECT_HI:`RBS_SELECT_LO];
		end
	end

	// Launch bit: set by a write, dropped on the next edge
	// A launch that finds a test running only raises the refused event
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			self_test_launch <= 1'b0;
		end else begin
			self_test_launch <= launch_we;
		end
	end

	// Clear bit: set by a write, dropped on the next edge
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			self_test_result_clear <= 1'b0;
		end else begin
			self_test_result_clear <= clear_we;
		end
	end

	// Launch decisions; the selection in force is the one after the write
	assign zero_select = (self_test_select == `RBS_SEL_NONE);
	// Prohibited codes are not blocked; they start like any other code
	assign start_ok    = self_test_launch & ~zero_select & idle;
	assign refused     = self_test_launch & running;
	assign zero_launch = self_test_launch & zero_select & idle;
	assign test_done   = TEST_RSP_IN.done & running;

	// Sequencer: idle until a valid launch, running until the engine reports
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			state           <= rbs_pkg::RBS_IDLE;
			captured_select <= `RBS_SEL_NONE;
		end else begin
			case (state)
				rbs_pkg::RBS_IDLE: begin
					if (start_ok) begin
						state           <= rbs_pkg::RBS_RUN;
						captured_select <= self_test_select;
					end
				end
				rbs_pkg::RBS_RUN: begin
					if (test_done) begin
						state <= rbs_pkg::RBS_IDLE;
					end
				end
				default: begin
					state <= rbs_pkg::RBS_IDLE;
				end
			endcase
		end
	end

	// Result code; a finishing test wins over a clear in the same cycle
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			self_test_result_code <= `RBS_CODE_CLEAR;
		end else if (test_done) begin
			if (TEST_RSP_IN.pass) begin
				self_test_result_code <= captured_select;
			end else begin
				self_test_result_code <= `RBS_CODE_FAIL;
			end
		end else if (zero_launch) begin
			self_test_result_code <= `RBS_CODE_CLEAR;
		end else if (self_test_result_clear) begin
			self_test_result_code <= `RBS_CODE_CLEAR;
		end
	end

	// Request towards the test engine: held steady through the run
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			TEST_REQ_OUT   <= '0;
			TEST_START_OUT <= 1'b0;
		end else begin
			TEST_START_OUT <= start_ok;
			if (start_ok) begin
				TEST_REQ_OUT.select <= self_test_select;
				TEST_REQ_OUT.adc_test_threshold <= adc_test_threshold;
				TEST_REQ_OUT.dual_path_error_test_exclude <= dual_path_error_test_exclude;
				TEST_REQ_OUT.dual_path_conv_test_exclude <= dual_path_conv_test_exclude;
			end
		end
	end

	// Event sources for the interrupt status bits
	assign events[`RBS_EV_PASS]    = test_done & TEST_RSP_IN.pass;
	assign events[`RBS_EV_FAIL]    = test_done & ~TEST_RSP_IN.pass;
	assign events[`RBS_EV_REFUSED] = refused;

	// Sticky status, one bit per event: a new event beats a clear of the same bit
	genvar ev;
	generate
		for (ev = 0; ev < `RBS_EV_W; ev = ev + 1) begin : g_status
			assign next_irq_status[ev] = events[ev]
				| (irq_status[ev] & ~(irq_clr_we & PWDATA_IN[ev]));
		end
	endgenerate

	// Enable register, low byte only
	always_comb begin
		next_irq_enable = irq_enable;
		if (irq_en_we) begin
			next_irq_enable = PWDATA_IN[`RBS_EV_W-1:0];
		end
	end

	// Status register
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			irq_status <= '0;
		end else begin
			irq_status <= next_irq_status;
		end
	end

	// Enable register
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			irq_enable <= '0;
		end else begin
			irq_enable <= next_irq_enable;
		end
	end

	// Level interrupt from the next values, so it rises with the status bit
	// and falls in the same cycle as a clear of the last enabled bit
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			IRQ_OUT <= 1'b0;
		end else begin
			IRQ_OUT <= |(next_irq_status & next_irq_enable);
		end
	end

endmodule

// ### sim/rbs_bist_monitor.sv
// Concurrent checks on the ports of the self-test status block
`include "rbs_params.svh"
module rbs_bist_monitor (
	input wire logic                   CLK_IN,
	input wire logic                   RESET_IN,
	input wire logic                   PSEL_IN,
	input wire logic                   PENABLE_IN,
	input wire logic                   PWRITE_IN,
	input wire logic [7:0]             PADDR_IN,
	input wire logic [31:0]            PWDATA_IN,
	input wire logic [3:0]             PSTRB_IN,
	input wire logic [31:0]            PRDATA_OUT,
	input wire logic                   PREADY_OUT,
	input wire logic                   PSLVERR_OUT,
	input wire logic                   IRQ_OUT,
	input wire rbs_pkg::rbs_test_req_s TEST_REQ_OUT,
	input wire logic                   TEST_START_OUT,
	input wire rbs_pkg::rbs_test_rsp_s TEST_RSP_IN
);
	logic       run;
	logic [3:0] sel_w;
	logic       wr_ctl;

	// Completed write to the control word
	assign wr_ctl = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN
		&& PADDR_IN == `RBS_OFF_CTRL && PSTRB_IN[0];

	// Mirror of the running state and the last selection written
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			run <= 1'b0;
			sel_w <= 4'h0;
		end else begin
			if (TEST_START_OUT)
				run <= 1'b1;
			else if (TEST_RSP_IN.done)
				run <= 1'b0;
			if (wr_ctl)
				sel_w <= PWDATA_IN[3:0];
		end
	end

	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RESET_IN);

	// Launch request accepted while idle
	sequence s_launch;
		wr_ctl && PWDATA_IN[`RBS_LAUNCH_BIT] && !run && !TEST_START_OUT;
	endsequence

	property p_start; s_launch ##0 (PWDATA_IN[3:0] != 4'h0) |-> ##2 TEST_START_OUT; endproperty
	property p_zero; s_launch ##0 (PWDATA_IN[3:0] == 4'h0) |=> !TEST_START_OUT [*2]; endproperty
	property p_busy; run |-> !TEST_START_OUT; endproperty
	property p_hold; run |-> $stable(TEST_REQ_OUT); endproperty
	property p_sel; TEST_START_OUT |-> TEST_REQ_OUT.select == sel_w; endproperty
	property p_ready; PSEL_IN && $rose(PENABLE_IN) |=> PREADY_OUT; endproperty
	property p_pulse; PREADY_OUT |-> PSEL_IN && PENABLE_IN ##1 !PREADY_OUT; endproperty
	property p_rsvd; PREADY_OUT && !PWRITE_IN && PADDR_IN == `RBS_OFF_CFG
		|-> (PRDATA_OUT & 32'hFCEEFEF0) == 32'h00000000; endproperty

	a_start: assert property (p_start) else $error("launch did not start a test");
	a_zero: assert property (p_zero) else $error("zero selection started a test");
	a_busy: assert property (p_busy) else $error("start while running");
	a_hold: assert property (p_hold) else $error("request changed while running");
	a_sel: assert property (p_sel) else $error("started with wrong selection");
	a_ready: assert property (p_ready) else $error("ready not in second access cycle");
	a_pulse: assert property (p_pulse) else $error("ready outside access or too long");
	a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
endmodule

bind rbs_bist_status rbs_bist_monitor rbs_bist_monitor_i (.CLK_IN, .RESET_IN, .PSEL_IN,
	.PENABLE_IN, .PWRITE_IN, .PADDR_IN, .PWDATA_IN, .PSTRB_IN, .PRDATA_OUT, .PREADY_OUT,
	.PSLVERR_OUT, .IRQ_OUT, .TEST_REQ_OUT, .TEST_START_OUT, .TEST_RSP_IN);

// ### sim/test_rbs_bist_status.sv
// Self-checking bench for the self-test status block
`include "rbs_params.svh"
module test_rbs_bist_status;
	timeunit 1ns;
	timeprecision 1ns;
	logic                   clk = 1'b0;
	logic                   rst = 1'b1;
	logic                   psel = 1'b0;
	logic                   pen = 1'b0;
	logic                   pwr = 1'b0;
	logic [7:0]             paddr = 8'h00;
	logic [31:0]            pwdata = 32'h00000000;
	logic [3:0]             pstrb = 4'h0;
	logic [31:0]            prdata;
	logic                   pready, pslverr, irq, start;
	rbs_pkg::rbs_test_req_s req;
	rbs_pkg::rbs_test_rsp_s rsp = 2'b00;
	int                     n_tests = 0;
	int                     bad_count = 0;
	logic [3:0]             codes [12] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9,
		4'hA, 4'hB, 4'hC, 4'hD, 4'hE};

	rbs_bist_status rbs_bist_status_i (.CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel),
		.PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
		.PSTRB_IN(pstrb), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
		.IRQ_OUT(irq), .TEST_REQ_OUT(req), .TEST_START_OUT(start), .TEST_RSP_IN(rsp));

	// 10 MHz clock
	always #50 clk = ~clk;

	// Expected image of the configuration and status word
	function automatic logic [31:0] cfg(input logic [1:0] t, input logic x, c, b,
			input logic [3:0] res);
		return {6'h00, t, 3'h0, x, 3'h0, c, 7'h00, b, 4'h0, res};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer, held until ready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] s, output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, 4'hF, r, e);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h00000000, 4'hF, r, e);
	endtask

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Hang guard
	initial begin
		#1000000;
		bad_count++;
		print_verdict();
	end

	// Main sequence
	initial begin
		logic [31:0] r;
		logic        e;
		logic [1:0]  thr, en;
		logic        ex, cx, ps;
		logic [3:0]  last;
		r = $urandom(32'h937D7C77);
		last = 4'h0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rd(`RBS_OFF_CFG, r);
		chk(r, `RBS_CFG_RESET);
		rd(`RBS_OFF_CTRL, r);
		chk(r, `RBS_CTRL_RESET);
		apb(1'b0, 8'h40, 32'h00000000, 4'hF, r, e);
		chk(e, 1'b1);
		apb(1'b1, `RBS_OFF_CFG, 32'h03110000, 4'h8, r, e);
		rd(`RBS_OFF_CFG, r);
		chk(r, cfg(2'h3, 1'b0, 1'b0, 1'b0, 4'h0));
		for (int i = 0; i < 12; i++) begin
			thr = 2'($urandom_range(3));
			en = 2'($urandom_range(3));
			ex = 1'($urandom_range(1));
			cx = 1'($urandom_range(1));
			ps = (i < 2) ? i[0] : 1'($urandom_range(1));
			wr(`RBS_OFF_CFG, cfg(thr, ex, cx, 1'b0, 4'h0));
			wr(`RBS_OFF_IRQ_EN, {30'h0, en});
			wr(`RBS_OFF_CTRL, `RBS_CTRL_RESET | 32'h00000100 | codes[i]);
			repeat (2) @(negedge clk);
			chk(start, 1'b1);
			@(negedge clk);
			chk(start, 1'b0);
			chk(req, {codes[i], thr, ex, cx});
			rd(`RBS_OFF_CFG, r);
			chk(r, cfg(thr, ex, cx, 1'b1, last));
			wr(`RBS_OFF_CTRL, `RBS_CTRL_RESET | 32'h00000100 | codes[i]);
			@(posedge clk);
			rsp <= {1'b1, ps};
			@(posedge clk);
			rsp <= 2'b00;
			last = ps ? codes[i] : `RBS_CODE_FAIL;
			rd(`RBS_OFF_CFG, r);
			chk(r, cfg(thr, ex, cx, 1'b0, last));
			rd(`RBS_OFF_IRQ_STAT, r);
			chk(r, {29'h0, 1'b1, !ps, ps});
			chk(irq, |({!ps, ps} & en));
			wr(`RBS_OFF_IRQ_CLR, 32'h00000007);
			rd(`RBS_OFF_IRQ_STAT, r);
			chk(r, 32'h00000000);
			chk(irq, 1'b0);
			if (i % 2 == 0) begin
				wr(`RBS_OFF_CTRL, `RBS_CTRL_RESET | 32'h00000100);
				rd(`RBS_OFF_CFG, r);
				chk(r, cfg(thr, ex, cx, 1'b0, 4'h0));
				last = 4'h0;
			end
		end
		apb(1'b1, `RBS_OFF_CTRL, 32'h00010000, 4'h4, r, e);
		rd(`RBS_OFF_CFG, r);
		chk(r, cfg(thr, ex, cx, 1'b0, 4'h0));
		rd(`RBS_OFF_CTRL, r);
		chk(r, `RBS_CTRL_RESET | codes[11]);
		print_verdict();
	end
endmodule
